// file: pdc_pkg.sv
// Package of constants and types for the power-down control block
package pdc_pkg;
    localparam int PDC_AW = 4;
    localparam int PDC_DW = 32;
    // Byte offsets
    localparam logic [PDC_AW-1:0] PDC_OFF_CTRL = 4'h0;
    localparam logic [PDC_AW-1:0] PDC_OFF_IE = 4'h4;
    localparam logic [PDC_AW-1:0] PDC_OFF_STAT = 4'h8;
    // Power-down field position within the control register
    localparam int PDC_PD_LSB = 10;
    localparam int PDC_PD_W = 6;
    localparam int PDC_GIE_BIT = 0;
    localparam int PDC_NONMASKABLE_INTERRUPT_ENABLE_BIT = 1;
    localparam logic [PDC_DW-1:0] PDC_CTRL_RST = 32'h0000_0000;
    localparam logic [PDC_DW-1:0] PDC_IE_RST = 32'h0000_0000;
    // Mode codes
    localparam logic [PDC_PD_W-1:0] PDC_PD_NONE = 6'h00;
    localparam logic [PDC_PD_W-1:0] PDC_PD_SLEEP_EN = 6'h09;
    localparam logic [PDC_PD_W-1:0] PDC_PD_SLEEP_ANY = 6'h11;
    localparam logic [PDC_PD_W-1:0] PDC_PD_CLK_STOP = 6'h1a;
    localparam logic [PDC_PD_W-1:0] PDC_PD_OSC_STOP = 6'h1c;
    // Timing
    localparam int PDC_CLK_MHZ = 100;
    localparam int PDC_ENTRY_DELAY_CYC = 9;
    localparam int PDC_RELOCK_US = 250;
    localparam int PDC_RELOCK_CYC = PDC_RELOCK_US * PDC_CLK_MHZ;
    localparam logic [PDC_DW-1:0] PDC_UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        PDC_ST_RUN = 3'b000,
        PDC_ST_PEND = 3'b001,
        PDC_ST_SLEEP = 3'b010,
        PDC_ST_CSTOP = 3'b011,
        PDC_ST_OSTOP = 3'b100
    } pdc_state_t;
endpackage : pdc_pkg

// file: pdc_relock_timer.sv
// Counter that holds the clock unused after a start pulse until the PLL re-locks
`timescale 1ns/1ps
module pdc_relock_timer #(
    parameter int CYCLES = 25000
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    output logic locked_o
);
    import pdc_pkg::*;
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_ff;
    logic busy_ff;
    wire done = (cnt_ff == CW'(CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else if (start_i) begin
            cnt_ff <= '0;
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            cnt_ff <= done ? cnt_ff : cnt_ff + 1'b1;
            busy_ff <= !done;
        end
    end

    assign locked_o = !busy_ff;
endmodule : pdc_relock_timer

// file: pdc_ctrl.sv
// Power-down mode controller with Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module pdc_ctrl #(
    parameter int NUM_IRQ = 16,
    parameter int RELOCK_CYC = pdc_pkg::PDC_RELOCK_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [pdc_pkg::PDC_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pdc_pkg::PDC_DW-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [pdc_pkg::PDC_DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic osc_stop_wake_i,
    input wire logic emu_attached_i,
    input wire logic emu_exec_req_i,
    input wire logic emu_pc_write_i,
    output logic cpu_clk_en_o,
    output logic dma_clk_en_o,
    output logic pll_out_en_o,
    output logic pll_in_en_o,
    output logic io_freeze_o,
    output logic periph_out_of_spec_o,
    output logic wake_service_o,
    output logic wake_resume_o,
    output logic emu_spin_idle_o,
    output logic emu_pc_write_fail_o,
    output logic [2:0] mode_o
);
    import pdc_pkg::*;

    logic [PDC_DW-1:0] ctrl_ff;
    logic [NUM_IRQ-1:0] ie_ff;
    pdc_state_t state_ff;
    pdc_state_t nxt_state;
    logic [3:0] dly_ff;
    logic [PDC_PD_W-1:0] mode_code_ff;
    logic [PDC_DW-1:0] rdata_ff;
    logic rd_done_ff;
    logic wake_service_ff;
    logic wake_resume_ff;
    logic relock_start_ff;
    logic relock_seen_ff;
    logic relock_ok;

    // Decode of a field code to a legal mode; reserved codes yield none
    function automatic logic [PDC_PD_W-1:0] pd_decode(input logic [PDC_PD_W-1:0] c);
        case (c)
            PDC_PD_SLEEP_EN, PDC_PD_SLEEP_ANY: pd_decode = c;
            PDC_PD_CLK_STOP, PDC_PD_OSC_STOP: pd_decode = c;
            default: pd_decode = PDC_PD_NONE;
        endcase
    endfunction : pd_decode

    function automatic logic [PDC_DW-1:0] be_merge(input logic [PDC_DW-1:0] old_v,
                                                   input logic [PDC_DW-1:0] new_v,
                                                   input logic [3:0] be);
        logic [PDC_DW-1:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        be_merge = r;
    endfunction : be_merge

    // Bus decode
    wire sel_ctrl = (avs_address_i == PDC_OFF_CTRL);
    wire sel_ie = (avs_address_i == PDC_OFF_IE);
    wire sel_stat = (avs_address_i == PDC_OFF_STAT);
    wire wr_ctrl = avs_write_i && sel_ctrl;
    wire wr_ie = avs_write_i && sel_ie;
    wire [PDC_DW-1:0] ctrl_new = be_merge(ctrl_ff, avs_writedata_i, avs_byteenable_i);
    wire [PDC_PD_W-1:0] pd_field = ctrl_new[PDC_PD_LSB +: PDC_PD_W];
    wire [PDC_PD_W-1:0] pd_written = pd_decode(pd_field);
    wire [PDC_DW-1:0] ie_merged = be_merge({{(PDC_DW-NUM_IRQ){1'b0}}, ie_ff},
                                           avs_writedata_i, avs_byteenable_i);
    wire [NUM_IRQ-1:0] ie_new = ie_merged[NUM_IRQ-1:0];

    // Wake decode
    wire any_irq = |irq_i;
    wire en_irq = |(irq_i & ie_ff);
    wire global_interrupt_enable = ctrl_ff[PDC_GIE_BIT];
    wire nonmaskable_interrupt_enable = ctrl_ff[PDC_NONMASKABLE_INTERRUPT_ENABLE_BIT];
    wire sleep_any = (mode_code_ff == PDC_PD_SLEEP_ANY);
    wire wake_en = (state_ff == PDC_ST_SLEEP) && en_irq;
    wire wake_any = (state_ff == PDC_ST_SLEEP) && sleep_any && any_irq;
    wire wake = wake_en || wake_any;
    wire service = wake_en && global_interrupt_enable && nonmaskable_interrupt_enable;
    wire arm = (mode_code_ff != PDC_PD_NONE) && !emu_attached_i;
    wire deep = (state_ff == PDC_ST_CSTOP) || (state_ff == PDC_ST_OSTOP);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PDC_ST_RUN: begin
                if (arm) begin
                    nxt_state = PDC_ST_PEND;
                end
            end
            PDC_ST_PEND: begin
                if (!arm) begin
                    nxt_state = PDC_ST_RUN;
                end else if (dly_ff == 4'(PDC_ENTRY_DELAY_CYC - 2)) begin
                    if (mode_code_ff == PDC_PD_CLK_STOP) begin
                        nxt_state = PDC_ST_CSTOP;
                    end else if (mode_code_ff == PDC_PD_OSC_STOP) begin
                        nxt_state = PDC_ST_OSTOP;
                    end else begin
                        nxt_state = PDC_ST_SLEEP;
                    end
                end
            end
            PDC_ST_SLEEP: begin
                if (wake || emu_attached_i) begin
                    nxt_state = PDC_ST_RUN;
                end
            end
            PDC_ST_CSTOP, PDC_ST_OSTOP: begin
                nxt_state = state_ff;
            end
            default: nxt_state = PDC_ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_ff <= PDC_ST_RUN;
            dly_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            dly_ff <= (state_ff == PDC_ST_PEND) ? dly_ff + 4'h1 : 4'h0;
        end
    end

    // Control register; field clears on wake so the CPU resumes running
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_ff <= PDC_CTRL_RST;
            mode_code_ff <= PDC_PD_NONE;
            ie_ff <= PDC_IE_RST[NUM_IRQ-1:0];
        end else begin
            if (wr_ctrl && !deep) begin
                ctrl_ff <= ctrl_new;
                mode_code_ff <= pd_written;
            end else if (wake) begin
                ctrl_ff[PDC_PD_LSB +: PDC_PD_W] <= PDC_PD_NONE;
                mode_code_ff <= PDC_PD_NONE;
            end else if (emu_attached_i && !deep) begin
                mode_code_ff <= PDC_PD_NONE;
            end
            if (wr_ie) begin
                ie_ff <= ie_new;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wake_service_ff <= 1'b0;
            wake_resume_ff <= 1'b0;
        end else begin
            wake_service_ff <= wake && service;
            wake_resume_ff <= wake && !service;
        end
    end

    // Relock wait starts once after a reset that ended the oscillator stop
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            relock_start_ff <= 1'b0;
            relock_seen_ff <= 1'b0;
        end else begin
            relock_start_ff <= osc_stop_wake_i && !relock_seen_ff;
            relock_seen_ff <= relock_seen_ff || osc_stop_wake_i;
        end
    end
    // Clocks stay off from reset release until the wait is under way
    wire relock_hold = (osc_stop_wake_i && !relock_seen_ff) || relock_start_ff;
    wire relock_ready = relock_ok && !relock_hold;

    pdc_relock_timer #(
        .CYCLES(RELOCK_CYC)
    ) u_relock (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .start_i(relock_start_ff),
        .locked_o(relock_ok)
    );

    // Bus slave: one wait cycle on read, writes accepted at once
    wire [PDC_DW-1:0] stat_word = {{(PDC_DW-8){1'b0}}, 3'h0, emu_attached_i, relock_ok,
                                   3'(state_ff)};
    wire [PDC_DW-1:0] rd_mux = sel_ctrl ? ctrl_ff :
                               sel_ie ? {{(PDC_DW-NUM_IRQ){1'b0}}, ie_ff} :
                               sel_stat ? stat_word : PDC_UNMAPPED_DATA;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_ff <= '0;
            rd_done_ff <= 1'b0;
        end else begin
            rd_done_ff <= avs_read_i && !rd_done_ff;
            if (avs_read_i && !rd_done_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end
    assign avs_waitrequest_o = avs_read_i && !rd_done_ff;
    assign avs_readdata_o = rdata_ff;

    // Clock gating and effects
    wire running = (state_ff == PDC_ST_RUN) || (state_ff == PDC_ST_PEND);
    assign cpu_clk_en_o = running && relock_ready;
    assign dma_clk_en_o = !deep && relock_ready;
    assign pll_out_en_o = (state_ff != PDC_ST_CSTOP);
    assign pll_in_en_o = (state_ff != PDC_ST_OSTOP);
    assign io_freeze_o = deep;
    assign periph_out_of_spec_o = deep;
    assign wake_service_o = wake_service_ff;
    assign wake_resume_o = wake_resume_ff;
    assign emu_spin_idle_o = deep && emu_exec_req_i;
    assign emu_pc_write_fail_o = deep && emu_pc_write_i;
    assign mode_o = 3'(state_ff);
endmodule : pdc_ctrl

// file: pdc_ctrl_properties.sv
// Concurrent checks on the power-down controller ports
`timescale 1ns/1ps
module pdc_ctrl_properties #(
    parameter int NUM_IRQ = 16,
    parameter int RELOCK_CYC = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [pdc_pkg::PDC_AW-1:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [pdc_pkg::PDC_DW-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic emu_attached_i,
    input wire logic emu_exec_req_i,
    input wire logic emu_pc_write_i,
    input wire logic cpu_clk_en_o,
    input wire logic dma_clk_en_o,
    input wire logic pll_out_en_o,
    input wire logic pll_in_en_o,
    input wire logic io_freeze_o,
    input wire logic periph_out_of_spec_o,
    input wire logic wake_service_o,
    input wire logic wake_resume_o,
    input wire logic emu_spin_idle_o,
    input wire logic emu_pc_write_fail_o,
    input wire logic [2:0] mode_o
);
    import pdc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire deep = (mode_o == 3'h3) || (mode_o == 3'h4);
    sequence s_sleep_req;
        avs_write_i && avs_address_i == PDC_OFF_CTRL && avs_byteenable_i[1] && !emu_attached_i
            && avs_writedata_i[15:10] == PDC_PD_SLEEP_EN && mode_o == 3'h0 && irq_i == '0;
    endsequence
    sequence s_pend_sleep;
        (mode_o == 3'h1)[*8] ##1 (mode_o == 3'h2);
    endsequence
    a_sleep_entry_delay: assert property (s_sleep_req |=> (mode_o == 3'h0) ##1 s_pend_sleep)
        else $error("sleep not entered nine cycles after write");
    a_sleep_clock_gate: assert property (mode_o == 3'h2 |-> !cpu_clk_en_o && dma_clk_en_o)
        else $error("sleep clock enables wrong");
    a_clock_stop_out: assert property (mode_o == 3'h3 |-> !pll_out_en_o && io_freeze_o
        && periph_out_of_spec_o) else $error("clock stop outputs wrong");
    a_osc_stop_out: assert property (mode_o == 3'h4 |-> !pll_in_en_o && io_freeze_o)
        else $error("oscillator stop outputs wrong");
    a_deep_mode_held: assert property (deep |=> mode_o == $past(mode_o))
        else $error("deep mode left without reset");
    a_sleep_no_irq: assert property (mode_o == 3'h2 && irq_i == '0 && !emu_attached_i
        |=> mode_o == 3'h2) else $error("sleep left without interrupt");
    a_wake_from_sleep: assert property (wake_service_o || wake_resume_o
        |-> mode_o == 3'h0 && $past(mode_o) == 3'h2) else $error("wake pulse outside sleep exit");
    a_emu_spin_fail: assert property (emu_spin_idle_o == (deep && emu_exec_req_i)
        && emu_pc_write_fail_o == (deep && emu_pc_write_i)) else $error("emulation spin wrong");
    a_emu_mask_mode: assert property (emu_attached_i && mode_o == 3'h0 |=> mode_o == 3'h0)
        else $error("mode entered with emulator attached");
endmodule : pdc_ctrl_properties

bind pdc_ctrl pdc_ctrl_properties #(.NUM_IRQ(NUM_IRQ), .RELOCK_CYC(RELOCK_CYC)) u_props (.*);

// file: tb_top.sv
// Self-checking bench for the power-down controller
`timescale 1ns/1ps
module tb_top;
    import pdc_pkg::*;
    localparam int RELOCK = 8;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [PDC_AW-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [PDC_DW-1:0] wdata = '0;
    logic [PDC_DW-1:0] rdata;
    logic [15:0] irq = '0;
    logic osc = 1'b0;
    logic emu_att = 1'b0;
    logic emu_exec = 1'b0;
    logic emu_pc = 1'b0;
    logic wt, cpu_en, dma_en, pll_out, pll_in, frz, oos, svc, res, spin, pcf;
    logic [2:0] mode;
    int fails = 0;
    int n_tests = 0;
    pdc_ctrl #(.NUM_IRQ(16), .RELOCK_CYC(RELOCK)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .irq_i(irq),
        .osc_stop_wake_i(osc), .emu_attached_i(emu_att), .emu_exec_req_i(emu_exec),
        .emu_pc_write_i(emu_pc), .cpu_clk_en_o(cpu_en), .dma_clk_en_o(dma_en),
        .pll_out_en_o(pll_out), .pll_in_en_o(pll_in), .io_freeze_o(frz),
        .periph_out_of_spec_o(oos), .wake_service_o(svc), .wake_resume_o(res),
        .emu_spin_idle_o(spin), .emu_pc_write_fail_o(pcf), .mode_o(mode));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge clk_i);
        while (wt !== 1'b0) begin
            @(posedge clk_i);
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rd_chk
    task automatic do_reset(input logic o);
        resetn_i <= 1'b0;
        osc <= o;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
    endtask : do_reset
    task automatic t_regs;
        rd_chk(PDC_OFF_CTRL, PDC_CTRL_RST);
        rd_chk(PDC_OFF_IE, PDC_IE_RST);
        wr_reg(PDC_OFF_IE, 32'h0000_0001);
        rd_chk(PDC_OFF_IE, 32'h0000_0001);
        wr_reg(PDC_OFF_CTRL, 32'h0000_0400);
        repeat (12) @(posedge clk_i);
        check(32'({mode, cpu_en}), 32'h1);
        rd_chk(PDC_OFF_CTRL, 32'h0000_0400);
        rd_chk(4'hc, PDC_UNMAPPED_DATA);
    endtask : t_regs
    task automatic t_enter(input logic [5:0] code, input logic [1:0] en);
        wr_reg(PDC_OFF_CTRL, {16'h0, code, 8'h0, en});
        repeat (10) @(posedge clk_i);
        check(32'({mode, cpu_en, dma_en}), 32'h9);
    endtask : t_enter
    task automatic t_wake(input logic [15:0] v, input logic [1:0] e);
        logic [1:0] seen;
        seen = 2'b00;
        irq <= v;
        repeat (4) begin
            @(posedge clk_i);
            #1;
            seen = seen | {svc, res};
        end
        irq <= '0;
        check(32'({seen, mode}), 32'({e, (e == 2'b00) ? 3'h2 : 3'h0}));
    endtask : t_wake
    task automatic t_deep(input logic [5:0] code, input logic [2:0] m, input logic [3:0] pe,
                          input logic o);
        int n;
        n = 0;
        wr_reg(PDC_OFF_CTRL, {16'h0, code, 10'h0});
        repeat (10) @(posedge clk_i);
        check(32'({mode, pll_out, pll_in, frz, oos}), 32'({m, pe}));
        irq <= 16'hffff;
        emu_exec <= 1'b1;
        emu_pc <= 1'b1;
        wr_reg(PDC_OFF_CTRL, 32'h0);
        check(32'({mode, spin, pcf}), 32'({m, 2'b11}));
        irq <= '0;
        emu_exec <= 1'b0;
        emu_pc <= 1'b0;
        do_reset(o);
        while (cpu_en !== 1'b1 && n < RELOCK + 4) begin
            n++;
            @(posedge clk_i);
        end
        check(32'({cpu_en, mode}), 32'h8);
        check(32'(n >= RELOCK - 2), 32'(o));
        osc <= 1'b0;
    endtask : t_deep
    task automatic t_emu;
        emu_att <= 1'b1;
        wr_reg(PDC_OFF_CTRL, {16'h0, PDC_PD_SLEEP_ANY, 10'h0});
        repeat (12) @(posedge clk_i);
        check(32'({mode, cpu_en}), 32'h1);
        emu_att <= 1'b0;
    endtask : t_emu
    task automatic finish_test;
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    initial begin
        do_reset(1'b0);
        t_regs();
        t_enter(PDC_PD_SLEEP_EN, 2'b11);
        t_wake(16'h0002, 2'b00);
        t_wake(16'h0001, 2'b10);
        rd_chk(PDC_OFF_CTRL, 32'h3);
        t_enter(PDC_PD_SLEEP_EN, 2'b01);
        t_wake(16'h0001, 2'b01);
        t_enter(PDC_PD_SLEEP_ANY, 2'b11);
        t_wake(16'h0020, 2'b01);
        t_deep(PDC_PD_CLK_STOP, 3'h3, 4'b0111, 1'b0);
        t_deep(PDC_PD_OSC_STOP, 3'h4, 4'b1011, 1'b1);
        t_emu();
        finish_test();
    end
endmodule : tb_top
